// ===== inc/ecp_pkg.sv
/*
 * Shared constants, types and decode helpers for the eight-channel
 * modulator: register addresses on the special-function bus, control
 * field positions, divider codes, reset values and counter widths.
 * Assumes an 8-bit special-function address and data path.
 */
package ecp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned FRAME_W      = 8;   // 256 channel clocks per frame
    localparam int unsigned FIVE_W       = 5;   // Duty bits used in 5-bit mode
    localparam int unsigned PRESCALE_W   = 3;   // Divides the fast clock by up to 8
    localparam int unsigned DIV_CODES    = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE = 8'h9b;
    localparam logic [NUM_CH-1:0][7:0] ADDR_DUTY = {
        8'hbe, 8'hbd, 8'hbc, 8'hbb, 8'hb6, 8'hb5, 8'hb4, 8'hb3};
    localparam logic [NUM_CH-1:0][7:0] ADDR_CTRL = {
        8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hd6, 8'hd5, 8'hd4, 8'hd3};

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RES_BIT = 2;   // 1 = 5-bit, 0 = 8-bit
    localparam int unsigned CTRL_DIV_LSB = 0;
    localparam int unsigned CTRL_DIV_W   = 2;
    localparam int unsigned CTRL_W       = 3;   // Bits 7..3 are not stored

    // Divider selections in the low two control bits
    typedef enum logic [1:0] {
        ECP_DIV_HALF = 2'h0,
        ECP_DIV_ONE  = 2'h1,
        ECP_DIV_TWO  = 2'h2,
        ECP_DIV_FOUR = 2'h3
    } ecp_div_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]        RST_ENABLE = 8'h00;
    localparam logic [7:0]        RST_DUTY   = 8'h00;
    localparam logic [CTRL_W-1:0] RST_CTRL   = 3'h0;
    localparam logic [7:0]        RST_RDATA  = 8'h00;

    // Result of matching an address against one register group
    typedef struct packed {
        logic       hit;
        logic [2:0] idx;
    } ecp_dec_t;

    function automatic ecp_dec_t ecpDecode(input logic [7:0] addr,
                                           input logic [NUM_CH-1:0][7:0] table_);
        ecp_dec_t r;
        r = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (addr == table_[i]) begin
                r.hit = 1'b1;
                r.idx = 3'(i);
            end
        end
        return r;
    endfunction

endpackage

// ===== verilog/ecp_prescale.sv
/*
 * Shared prescaler. One free-running counter on the fast clock yields a
 * tick for each of the four divider selections.
 * Assumes clk runs at twice the oscillator rate, so that the half
 * divider is simply every fast clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ecp_prescale
    import ecp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    output logic      [DIV_CODES-1:0] tick
);

    typedef struct packed {
        logic [PRESCALE_W-1:0] cnt;
    } ecp_pre_state_t;

    ecp_pre_state_t s_q;
    ecp_pre_state_t s_d;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Free running so all channels share one phase; a divider change
    // takes effect on the next matching tick rather than restarting.
    always_comb begin
        s_d     = s_q;
        s_d.cnt = s_q.cnt + PRESCALE_W'(1);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Divide by 1, 2, 4 and 8 of the fast clock
    assign tick[ECP_DIV_HALF] = 1'b1;
    assign tick[ECP_DIV_ONE]  = &s_q.cnt[0:0];
    assign tick[ECP_DIV_TWO]  = &s_q.cnt[1:0];
    assign tick[ECP_DIV_FOUR] = &s_q.cnt[2:0];

endmodule

`default_nettype wire

// ===== verilog/ecp_channel.sv
/*
 * One modulated channel: a frame counter that advances on its channel
 * clock tick and a compare against the duty value.
 * Assumes tick, enable and configuration come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ecp_channel
    import ecp_pkg::*;
#(
    parameter int unsigned FRAME_BITS = FRAME_W
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              enable,
    input  wire logic              tick,
    input  wire logic              fiveBit,
    input  wire logic [DATA_W-1:0] duty,
    output logic                   pwmOut
);

    typedef struct packed {
        logic [FRAME_BITS-1:0] cnt;
        logic                  out;
    } ecp_ch_state_t;

    ecp_ch_state_t s_q;
    ecp_ch_state_t s_d;

    // ------------------------------------------------------------
    // Frame counter and compare
    // ------------------------------------------------------------
    // The compare uses the next count so out_q lines up with cnt_q.
    always_comb begin
        s_d = s_q;
        if (!enable) begin
            s_d.cnt = '0;
        end else if (tick) begin
            s_d.cnt = s_q.cnt + FRAME_BITS'(1);
        end
        if (!enable) begin
            s_d.out = 1'b0;
        end else if (fiveBit) begin
            // Upper duty bits are ignored; 32-clock slots repeat in the frame
            s_d.out = s_d.cnt[FIVE_W-1:0] < duty[FIVE_W-1:0];
        end else begin
            s_d.out = s_d.cnt < duty[FRAME_BITS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwmOut = s_q.out;

endmodule

`default_nettype wire

// ===== verilog/ecp_top.sv
/*
 * Eight-channel pulse width modulator with its special-function
 * registers: channel enable, eight control and eight duty registers,
 * and the port 1 output multiplexer.
 * Assumes a single-cycle write strobe and read strobe from the core on
 * clk, a port 1 latch value from the port block on the same clock, and
 * clk running at twice the oscillator rate.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Eight independent channels each drive one port 1 pin instead of the port latch.
// - Each channel picks 5-bit or 8-bit resolution and times from the oscillator clock.
// - A channel runs only while its bit n in the enable register is 1.
// - Every channel has its own control and duty register, isolated from the others.
// - Control bit 2 set selects 5-bit, clear selects 8-bit; bits 7 to 3 are unused.
// - Control bits 1 and 0 select a divider of 0.5, 1, 2 or 4 for codes 00 to 11.
// - The channel clock is the oscillator rate over the divider, so 0.5 needs a doubled clock.
// - A frame lasts 256 channel clocks.
// - The duty register value sets the duty cycle, one register per channel.
// - In 5-bit mode only the low five duty bits are used.
module ecp_top
    import ecp_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CH
)
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic [7:0]          sfrAddr,
    input  wire logic                sfrWrEn,
    input  wire logic [DATA_W-1:0]   sfrWrData,
    input  wire logic                sfrRdEn,
    output logic      [DATA_W-1:0]   sfrRdData,
    output logic                     sfrRdHit,
    input  wire logic [CHANNELS-1:0] portLatch,
    output logic      [CHANNELS-1:0] p1Out,
    output logic      [CHANNELS-1:0] p1PwmSel
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Control registers keep only the three defined bits; the unused
    // upper bits cost no flops and read back as zero.
    typedef struct packed {
        logic [CHANNELS-1:0]             enable;
        logic [CHANNELS-1:0][CTRL_W-1:0] ctrl;
        logic [CHANNELS-1:0][DATA_W-1:0] duty;
        logic [DATA_W-1:0]               rdData;
        logic                            rdHit;
        logic [CHANNELS-1:0]             pinOut;
        logic [CHANNELS-1:0]             pinSel;
    } ecp_top_state_t;

    ecp_top_state_t s_q;
    ecp_top_state_t s_d;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic     enHit;
    ecp_dec_t dutyDec;
    ecp_dec_t ctrlDec;

    // Shared by the write and read paths
    assign enHit   = (sfrAddr == ADDR_ENABLE);
    assign dutyDec = ecpDecode(sfrAddr, ADDR_DUTY);
    assign ctrlDec = ecpDecode(sfrAddr, ADDR_CTRL);

    // ------------------------------------------------------------
    // Channel clock ticks
    // ------------------------------------------------------------
    logic [DIV_CODES-1:0] divTick;

    ecp_prescale u_prescale (
        .clk  (clk),
        .nrst (nrst),
        .tick (divTick)
    );

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] chTick;
    logic [CHANNELS-1:0] chFive;
    logic [CHANNELS-1:0] chPwm;

    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
            // Each channel picks its own tick from its own control bits
            assign chTick[g] = divTick[s_q.ctrl[g][CTRL_DIV_LSB +: CTRL_DIV_W]];
            assign chFive[g] = s_q.ctrl[g][CTRL_RES_BIT];

            ecp_channel #(
                .FRAME_BITS (FRAME_W)
            ) u_ch (
                .clk     (clk),
                .nrst    (nrst),
                .enable  (s_q.enable[g]),
                .tick    (chTick[g]),
                .fiveBit (chFive[g]),
                .duty    (s_q.duty[g]),
                .pwmOut  (chPwm[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Register writes land on the strobe edge; only the addressed
        // channel's register changes
        if (sfrWrEn) begin
            if (enHit) begin
                s_d.enable = sfrWrData[CHANNELS-1:0];
            end
            if (dutyDec.hit) begin
                s_d.duty[dutyDec.idx] = sfrWrData;
            end
            if (ctrlDec.hit) begin
                s_d.ctrl[ctrlDec.idx] = sfrWrData[CTRL_W-1:0];
            end
        end

        // Read data is held until the next read strobe; an address
        // outside the map answers zero with the hit flag low
        if (sfrRdEn) begin
            s_d.rdHit  = enHit | dutyDec.hit | ctrlDec.hit;
            s_d.rdData = RST_RDATA;
            if (enHit) begin
                s_d.rdData = DATA_W'(s_q.enable);
            end else if (dutyDec.hit) begin
                s_d.rdData = s_q.duty[dutyDec.idx];
            end else if (ctrlDec.hit) begin
                s_d.rdData = DATA_W'(s_q.ctrl[ctrlDec.idx]);
            end
        end

        // Pin mux: modulator while enabled, port latch otherwise.
        // Registering it costs one clock of delay but keeps the pins glitch free.
        for (int i = 0; i < CHANNELS; i++) begin
            s_d.pinSel[i] = s_q.enable[i];
            s_d.pinOut[i] = s_q.enable[i] ? chPwm[i] : portLatch[i];
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q.enable <= RST_ENABLE[CHANNELS-1:0];
            s_q.ctrl   <= {CHANNELS{RST_CTRL}};
            s_q.duty   <= {CHANNELS{RST_DUTY}};
            s_q.rdData <= RST_RDATA;
            s_q.rdHit  <= 1'b0;
            s_q.pinOut <= '0;
            s_q.pinSel <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfrRdData = s_q.rdData;
    assign sfrRdHit  = s_q.rdHit;
    assign p1Out     = s_q.pinOut;
    assign p1PwmSel  = s_q.pinSel;

endmodule

`default_nettype wire

// ===== tb/ecp_top_asserts.sv
/*
 * Port-level checker for the eight-channel modulator.
 * Assumes it is bound to ecp_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module ecp_top_asserts
    import ecp_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CH
)
(
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic [7:0]          sfrAddr,
    input wire logic                sfrWrEn,
    input wire logic [DATA_W-1:0]   sfrWrData,
    input wire logic                sfrRdEn,
    input wire logic [DATA_W-1:0]   sfrRdData,
    input wire logic                sfrRdHit,
    input wire logic [CHANNELS-1:0] portLatch,
    input wire logic [CHANNELS-1:0] p1Out,
    input wire logic [CHANNELS-1:0] p1PwmSel
);
    // --------------------------------------------------------
    // Address classes
    // --------------------------------------------------------
    logic ctrlAddr;
    logic mapped;
    assign ctrlAddr = sfrAddr inside {8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hdb, 8'hdc, 8'hdd, 8'hde};
    assign mapped   = ctrlAddr || sfrAddr inside {8'h9b, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hbb, 8'hbc, 8'hbd, 8'hbe};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // A lone enable write, so a later write cannot mask the first
    sequence s_enable_write;
        sfrWrEn && sfrAddr == ADDR_ENABLE ##1 !(sfrWrEn && sfrAddr == ADDR_ENABLE);
    endsequence

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    a_enable_write: assert property (s_enable_write |=> p1PwmSel == $past(sfrWrData[CHANNELS-1:0], 2))
        else $error("pin ownership does not follow enable write");
    a_sel_cause: assert property ($changed(p1PwmSel) && $past(nrst) && $past(nrst, 2)
        |-> $past(sfrWrEn, 2) && $past(sfrAddr, 2) == ADDR_ENABLE)
        else $error("pin ownership changed without enable write");
    a_port_follow: assert property ($past(nrst) |-> (~p1PwmSel & p1Out) == (~p1PwmSel & $past(portLatch)))
        else $error("disabled pin does not carry port latch");
    a_read_hit: assert property (sfrRdEn |=> sfrRdHit == $past(mapped))
        else $error("read hit flag wrong");
    a_unmapped_zero: assert property (sfrRdEn && !mapped |=> sfrRdData == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_upper: assert property (sfrRdEn && ctrlAddr |=> sfrRdData[7:3] == 5'h00)
        else $error("unused control bits read nonzero");
    a_read_holds: assert property (!sfrRdEn |=> $stable(sfrRdData) && $stable(sfrRdHit))
        else $error("read data changed without strobe");
    a_enable_back: assert property (sfrRdEn && sfrAddr == ADDR_ENABLE |=> sfrRdData[CHANNELS-1:0] == p1PwmSel)
        else $error("enable readback disagrees with pin ownership");
endmodule

`default_nettype wire

// ===== tb/ecp_pin_load.sv
/*
 * Load on the eight port pins: counts high samples and rising edges
 * per pin while measure is high. Assumes pins settle after each edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ecp_pin_load (
    input  wire logic        clk,
    input  wire logic [7:0]  pins,
    input  wire logic        clr,
    input  wire logic        measure,
    output logic [7:0][15:0] highCnt,
    output logic [7:0][15:0] riseCnt
);
    logic [7:0] prev;

    // Edge count over whole periods is phase independent
    always_ff @(posedge clk) begin
        prev <= pins;
        for (int i = 0; i < 8; i++) begin
            if (clr) begin
                highCnt[i] <= '0;
                riseCnt[i] <= '0;
            end else if (measure) begin
                highCnt[i] <= highCnt[i] + 16'(pins[i]);
                riseCnt[i] <= riseCnt[i] + 16'(pins[i] & ~prev[i]);
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/test_ecp_top.sv
/*
 * Self-checking bench for ecp_top: registers, pin ownership, waveforms.
 * Assumes clk is twice the oscillator rate, as the design does.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ecp_top;
    import ecp_pkg::*;
    logic clk, nrst, sfrWrEn, sfrRdEn, sfrRdHit, clrCnt, measure;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, portLatch, p1Out, p1PwmSel;
    logic [7:0][15:0] highCnt, riseCnt;
    int failures, nChecks;

    ecp_top i_ecp_top (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit), .portLatch(portLatch),
        .p1Out(p1Out), .p1PwmSel(p1PwmSel));
    ecp_pin_load i_ecp_pin_load (.clk(clk), .pins(p1Out), .clr(clrCnt), .measure(measure),
        .highCnt(highCnt), .riseCnt(riseCnt));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a; sfrWrData <= d; sfrWrEn <= 1'b1;
        @(posedge clk);
        sfrWrEn <= 1'b0;
    endtask

    // Data lands at the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic hit);
        @(posedge clk);
        sfrAddr <= a; sfrRdEn <= 1'b1;
        @(posedge clk);
        sfrRdEn <= 1'b0;
        #1;
        check(sfrRdData, d);
        check(sfrRdHit, hit);
    endtask

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_reset_vals();
        rd(ADDR_ENABLE, 8'h00, 1'b1);
        rd(ADDR_DUTY[0], 8'h00, 1'b1);
        rd(ADDR_CTRL[7], 8'h00, 1'b1);
        rd(8'h97, 8'h00, 1'b0);
    endtask

    // Upper control bits written as ones must not stick
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_DUTY[i], 8'(8'h30 + i));
            wr(ADDR_CTRL[i], 8'(8'hf8 | i));
        end
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_DUTY[i], 8'(8'h30 + i), 1'b1);
            rd(ADDR_CTRL[i], 8'(i), 1'b1);
        end
    endtask

    // Port latch moves on a clock edge; pins are read once settled
    task automatic t_port();
        @(posedge clk);
        portLatch <= 8'ha5;
        wr(ADDR_ENABLE, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        check(p1Out, 8'ha5);
        wr(ADDR_ENABLE, 8'h08);
        repeat (3) @(posedge clk);
        #1;
        check(p1PwmSel, 8'h08);
        check(p1Out & 8'hf7, 8'ha5 & 8'hf7);
    endtask

    // Window of 2048 clocks holds whole frames for every divider
    task automatic t_wave();
        logic [7:0] duty [8] = '{8'h01, 8'h80, 8'hff, 8'h37, 8'he5, 8'h1f, 8'h20, 8'h0a};
        int code, per, ticks, dEff;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL[i], {5'h15, i >= 4, 2'(i)});
            wr(ADDR_DUTY[i], duty[i]);
        end
        wr(ADDR_ENABLE, 8'hff);
        repeat (2100) @(posedge clk);
        clrCnt <= 1'b1;
        @(posedge clk);
        clrCnt <= 1'b0; measure <= 1'b1;
        repeat (2048) @(posedge clk);
        measure <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            code = i % 4;
            per = (i >= 4) ? 32 : 256;
            dEff = (i >= 4) ? int'(duty[i][4:0]) : int'(duty[i]);
            ticks = 2048 >> code;
            check(highCnt[i], 16'(dEff * (ticks / per) * (1 << code)));
            check(riseCnt[i], 16'((dEff != 0) ? ticks / per : 0));
        end
    endtask

    // --------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------
    initial begin
        clk = 0; nrst = 0; sfrAddr = 0; sfrWrEn = 0; sfrWrData = 0;
        sfrRdEn = 0; portLatch = 0; clrCnt = 1; measure = 0;
        failures = 0; nChecks = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        clrCnt <= 1'b0;
        t_reset_vals();
        t_regs();
        t_port();
        t_wave();
        conclude();
    end

    initial begin
        #(5 * 20000);
        failures++;
        conclude();
    end
endmodule

bind ecp_top ecp_top_asserts #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .sfrRdHit(sfrRdHit), .portLatch(portLatch), .p1Out(p1Out), .p1PwmSel(p1PwmSel));

`default_nettype wire
